/* core/drmc_top.sv */
// Behaviour
// - Two-bit code limits phase slope rate
// - Realign bit aligns output to reference phase
// - Bandwidth code doubles; 111 uses variable value
// - Three-bit rank per input; 111 disables
// - Auto mode reverts to lower-numbered available rank
// - Equal ranks never cause a switch
// - Mode code picks freerun/hold/forced/auto
// - Auto holdover only when no input usable
// - Forced input failing means holdover only
// - Forced holdover keeps last chosen input
// - Freerun uses local oscillator only
// - Chosen field: status in auto, selector forced
// - Compensate enable applies shared feedback phase
// - Low hold mask bit blocks holdover cause
// - Low switch mask bit blocks switch cause
// - Sticky hold flags, bit 0 and 2
// - Sticky lock flags, bit 1 and 3
// - Feedback PLL choice selects measured PLL
// - Feedback input choice picks reference 0..3
// - Global feedback enable; eight low-power bits set
`timescale 1ns/10ps

module drmc_top
  import drmc_pkg::*;
(
  input  wire logic       MCLK,              // 50 MHz system clock
  input  wire logic       NRST,              // Asynchronous reset, active low
  input  wire logic [7:0] REG_ADDR,          // Register offset
  input  wire logic       REG_WR,            // Write strobe, one cycle
  input  wire logic [7:0] REG_WDATA,         // Write data
  output logic      [7:0] REG_RDATA,         // Read data, one cycle after address
  input  wire logic [3:0] SIGNAL_LOSS_DETECT,  // Per input, asynchronous
  input  wire logic [3:0] SINGLE_CYCLE_DETECT, // Per input, asynchronous
  input  wire logic [3:0] COARSE_FREQ_DETECT,  // Per input, asynchronous
  input  wire logic [3:0] GUARD_TIMER_DETECT,  // Per input, asynchronous
  input  wire logic       PLL_A_IN_HOLD,     // First PLL in holdover
  input  wire logic       PLL_A_LOCKED,      // First PLL locked
  input  wire logic       PLL_B_LOOP_LOCKED, // Second PLL loop reports lock
  output logic      [1:0] SLOPE_RATE_SELECT,
  output logic            PHASE_REALIGN_ENABLE,
  output logic      [2:0] FILTER_BANDWIDTH_SELECT,
  output logic            USE_VARIABLE_BANDWIDTH,
  output logic            SLOPE_UNLIMITED_EN,
  output logic      [1:0] ACTIVE_INPUT,
  output logic            TRACKING,
  output logic            HOLDOVER,
  output logic            FREERUN,
  output logic            FEEDBACK_COMPENSATE_ENABLE,
  output logic            FEEDBACK_PLL_CHOICE,
  output logic      [1:0] FEEDBACK_INPUT_CHOICE,
  output logic            FEEDBACK_GLOBAL_ENABLE,
  output logic      [7:0] OUT_LOW_POWER
);
  import drmc_pkg::*;

  // Register storage
  logic [7:0]  loop_control;            // Slope, realign, bandwidth
  logic [7:0]  priority_upper;          // Ranks of inputs 2 and 3
  logic [7:0]  priority_lower;          // Ranks of inputs 0 and 1
  logic [7:0]  operating_select;        // Mode, compensate, forced input
  logic [7:0]  failure_masks;           // Hold and switch masks
  logic [7:0]  sticky_status;           // Sticky lock and hold flags
  logic [7:0]  feedback_control;        // Feedback path control
  logic [7:0]  diff_low_power;          // Low-power enables

  // Synchroniser for all asynchronous inputs
  logic [18:0] sync_meta;               // First stage, read only by stage two
  logic [18:0] sync_q;                  // Second stage, safe to use
  wire  [18:0] async_in = {PLL_B_LOOP_LOCKED, PLL_A_LOCKED, PLL_A_IN_HOLD,
                           GUARD_TIMER_DETECT, COARSE_FREQ_DETECT,
                           SINGLE_CYCLE_DETECT, SIGNAL_LOSS_DETECT};

  // Selection state
  drmc_state_t state;                   // Loop condition
  drmc_state_t next_state;
  logic [1:0]  cur_input;               // Last selected input
  logic [1:0]  next_input;

  // Decoded write strobes
  wire wr_loop   = REG_WR && (REG_ADDR == ADDR_LOOP_CONTROL);
  wire wr_upper  = REG_WR && (REG_ADDR == ADDR_PRIORITY_UPPER);
  wire wr_lower  = REG_WR && (REG_ADDR == ADDR_PRIORITY_LOWER);
  wire wr_opsel  = REG_WR && (REG_ADDR == ADDR_OPERATING_SEL);
  wire wr_masks  = REG_WR && (REG_ADDR == ADDR_FAILURE_MASKS);
  wire wr_sticky = REG_WR && (REG_ADDR == ADDR_STICKY_STATUS);
  wire wr_fbctl  = REG_WR && (REG_ADDR == ADDR_FEEDBACK_CTRL);
  wire wr_lowpw  = REG_WR && (REG_ADDR == ADDR_LOW_POWER);

  // Synchronised detector vectors
  wire [3:0] loss_s  = sync_q[3:0];
  wire [3:0] cycle_s = sync_q[7:4];
  wire [3:0] coarse_s = sync_q[11:8];
  wire [3:0] guard_s = sync_q[15:12];
  wire       a_hold_s = sync_q[16];
  wire       a_lock_s = sync_q[17];
  wire       b_loop_s = sync_q[18];

  // Fields
  wire [1:0]  mode_code   = operating_select[MODE_LSB +: 2];
  wire [1:0]  forced_sel  = operating_select[CHOSEN_LSB +: 2];
  wire [3:0]  hold_mask   = failure_masks[HOLD_MASK_LSB +: 4];
  wire [3:0]  switch_mask = failure_masks[SW_MASK_LSB +: 4];
  wire [2:0]  rank [4];
  assign rank[0] = priority_lower[RANK_LO_LSB +: 3];
  assign rank[1] = priority_lower[RANK_HI_LSB +: 3];
  assign rank[2] = priority_upper[RANK_LO_LSB +: 3];
  assign rank[3] = priority_upper[RANK_HI_LSB +: 3];

  // Per-input failure causes after masking
  logic [3:0] hold_fail;                // Failure that may force holdover
  logic [3:0] switch_fail;              // Failure that may force a switch
  logic [3:0] usable;                   // Candidate for automatic selection

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_input
      wire [3:0] det = {guard_s[gi], coarse_s[gi], cycle_s[gi], loss_s[gi]};
      // Masked detectors cannot push into holdover
      assign hold_fail[gi]   = |(det & hold_mask);
      // Masked detectors cannot trigger a switch
      assign switch_fail[gi] = |(det & switch_mask);
      // A disabled rank drops the input from selection
      assign usable[gi] = (rank[gi] != RANK_DISABLED) && !switch_fail[gi];
    end
  endgenerate

  // Best usable input: lowest rank, lowest index on ties
  logic [1:0] best_input;
  logic [2:0] best_rank;
  always_comb begin
    best_input = 2'h0;
    best_rank  = RANK_DISABLED;
    for (int i = 3; i >= 0; i--) begin
      if (usable[i] && (rank[i] <= best_rank)) begin
        best_input = 2'(i);
        best_rank  = rank[i];
      end
    end
  end

  wire any_usable = |usable;
  // Stay put while the current input ranks level with the best
  wire keep_current = usable[cur_input] && (rank[cur_input] == best_rank);

  // Mode decode and next selection
  always_comb begin
    next_state = state;
    next_input = cur_input;
    case (drmc_mode_t'(mode_code))
      MODE_FREERUN: begin
        next_state = ST_FREERUN;
      end
      MODE_HOLD: begin
        // References ignored, last selection kept for holdover
        next_state = ST_HOLDOVER;
      end
      MODE_FORCED: begin
        // Only the programmed input; failure means holdover
        next_input = forced_sel;
        next_state = hold_fail[forced_sel] ? ST_HOLDOVER : ST_TRACK;
      end
      MODE_AUTO: begin
        if (any_usable) begin
          // Revert to a strictly better rank or leave an unusable current input, else keep current
          next_input = keep_current ? cur_input : best_input;
          next_state = ST_TRACK;
        end else begin
          // Holdover only once nothing is usable
          next_state = hold_fail[cur_input] ? ST_HOLDOVER : ST_TRACK;
        end
      end
      default: begin
        next_state = ST_FREERUN;
      end
    endcase
  end

  // Two-flop synchroniser
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      sync_meta <= '0;
      sync_q    <= '0;
    end else begin
      sync_meta <= async_in;
      sync_q    <= sync_meta;
    end
  end

  // Selection state machine
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      state     <= ST_FREERUN;
      cur_input <= 2'h0;
    end else begin
      state     <= next_state;
      cur_input <= next_input;
    end
  end

  // Reserved bits keep their reset value on every write
  function automatic logic [7:0] merge(input logic [7:0] wd, input logic [7:0] wm,
                                       input logic [7:0] rv);
    merge = (wd & wm) | (rv & ~wm);
  endfunction

  // Configuration registers
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      loop_control     <= RST_LOOP_CONTROL;
      priority_upper   <= RST_PRIORITY_UPPER;
      priority_lower   <= RST_PRIORITY_LOWER;
      operating_select <= RST_OPERATING_SEL;
      failure_masks    <= RST_FAILURE_MASKS;
      feedback_control <= RST_FEEDBACK_CTRL;
      diff_low_power   <= RST_LOW_POWER;
    end else begin
      if (wr_loop) begin
        loop_control <= merge(REG_WDATA, WMASK_LOOP_CONTROL, RST_LOOP_CONTROL);
      end
      if (wr_upper) begin
        priority_upper <= merge(REG_WDATA, WMASK_PRIORITY, RST_PRIORITY_UPPER);
      end
      if (wr_lower) begin
        priority_lower <= merge(REG_WDATA, WMASK_PRIORITY, RST_PRIORITY_LOWER);
      end
      if (wr_opsel) begin
        operating_select <= merge(REG_WDATA, WMASK_OPERATING_SEL, RST_OPERATING_SEL);
      end
      if (wr_masks) begin
        failure_masks <= merge(REG_WDATA, WMASK_FAILURE_MASKS, RST_FAILURE_MASKS);
      end
      if (wr_fbctl) begin
        feedback_control <= merge(REG_WDATA, WMASK_FEEDBACK_CTRL, RST_FEEDBACK_CTRL);
      end
      if (wr_lowpw) begin
        diff_low_power <= merge(REG_WDATA, WMASK_LOW_POWER, RST_LOW_POWER);
      end
    end
  end

  // Sticky flag sources
  wire       b_hold = (state == ST_HOLDOVER);
  wire       b_lock = (state == ST_TRACK) && b_loop_s;
  logic [7:0] sticky_set;
  always_comb begin
    sticky_set              = 8'h00;
    sticky_set[A_HOLD_BIT]  = a_hold_s;
    sticky_set[B_HOLD_BIT]  = b_hold;
    sticky_set[A_LOCK_BIT]  = a_lock_s;
    sticky_set[B_LOCK_BIT]  = b_lock;
  end
  wire [7:0] sticky_clr = wr_sticky ? (REG_WDATA & WMASK_STICKY) : 8'h00;

  // Sticky register: write one to clear, a new event wins
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      sticky_status <= RST_STICKY_STATUS;
    end else begin
      sticky_status <= (sticky_status & ~sticky_clr) | sticky_set;
    end
  end

  // Chosen field shows the live choice in automatic mode only
  wire [7:0] opsel_view = (mode_code == MODE_AUTO) ?
                          {cur_input, operating_select[5:0]} : operating_select;

  // Read mux, unmapped offsets read zero
  logic [7:0] rd_mux;
  always_comb begin
    case (REG_ADDR)
      ADDR_LOOP_CONTROL:   rd_mux = loop_control;
      ADDR_PRIORITY_UPPER: rd_mux = priority_upper;
      ADDR_PRIORITY_LOWER: rd_mux = priority_lower;
      ADDR_OPERATING_SEL:  rd_mux = opsel_view;
      ADDR_FAILURE_MASKS:  rd_mux = failure_masks;
      ADDR_STICKY_STATUS:  rd_mux = sticky_status;
      ADDR_FEEDBACK_CTRL:  rd_mux = feedback_control;
      ADDR_LOW_POWER:      rd_mux = diff_low_power;
      default:             rd_mux = 8'h00;
    endcase
  end

  // Registered outputs
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      REG_RDATA                  <= 8'h00;
      SLOPE_RATE_SELECT          <= RST_LOOP_CONTROL[SLOPE_LSB +: 2];
      SLOPE_UNLIMITED_EN         <= 1'b0;
      PHASE_REALIGN_ENABLE       <= 1'b0;
      FILTER_BANDWIDTH_SELECT    <= 3'h0;
      USE_VARIABLE_BANDWIDTH     <= 1'b0;
      ACTIVE_INPUT               <= 2'h0;
      TRACKING                   <= 1'b0;
      HOLDOVER                   <= 1'b0;
      FREERUN                    <= 1'b1;
      FEEDBACK_COMPENSATE_ENABLE <= 1'b0;
      FEEDBACK_PLL_CHOICE        <= 1'b0;
      FEEDBACK_INPUT_CHOICE      <= 2'h0;
      FEEDBACK_GLOBAL_ENABLE     <= 1'b0;
      OUT_LOW_POWER              <= RST_LOW_POWER;
    end else begin
      REG_RDATA                  <= rd_mux;
      SLOPE_RATE_SELECT          <= loop_control[SLOPE_LSB +: 2];
      SLOPE_UNLIMITED_EN <= (loop_control[SLOPE_LSB +: 2] == SLOPE_UNLIMITED);
      PHASE_REALIGN_ENABLE       <= loop_control[REALIGN_BIT];
      FILTER_BANDWIDTH_SELECT    <= loop_control[BW_LSB +: 3];
      USE_VARIABLE_BANDWIDTH     <= (loop_control[BW_LSB +: 3] == BW_VARIABLE);
      ACTIVE_INPUT               <= cur_input;
      TRACKING                   <= (state == ST_TRACK);
      HOLDOVER                   <= (state == ST_HOLDOVER);
      FREERUN                    <= (state == ST_FREERUN);
      FEEDBACK_COMPENSATE_ENABLE <= operating_select[FB_COMP_BIT];
      FEEDBACK_PLL_CHOICE        <= feedback_control[FB_PLL_BIT];
      FEEDBACK_INPUT_CHOICE      <= feedback_control[FB_INPUT_LSB +: 2];
      FEEDBACK_GLOBAL_ENABLE     <= feedback_control[FB_GLOBAL_BIT];
      OUT_LOW_POWER              <= diff_low_power;
    end
  end

  // Checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);

  property p_auto_hold;
    (mode_code == MODE_AUTO) && !any_usable && hold_fail[cur_input] |=> (state == ST_HOLDOVER);
  endproperty
  a_auto_hold: assert property (p_auto_hold)
    else $error("auto mode did not enter holdover");

  property p_auto_track;
    (mode_code == MODE_AUTO) && any_usable |=> (state == ST_TRACK);
  endproperty
  a_auto_track: assert property (p_auto_track)
    else $error("auto mode entered holdover with usable input");

  property p_forced;
    (mode_code == MODE_FORCED) |=> (cur_input == $past(forced_sel)) &&
      ((state == ST_HOLDOVER) == $past(hold_fail[forced_sel]));
  endproperty
  a_forced: assert property (p_forced)
    else $error("forced mode left its programmed input");

  sequence s_hold_mode;
    (mode_code == MODE_HOLD) ##1 (mode_code == MODE_HOLD);
  endsequence
  property p_forced_hold;
    s_hold_mode |-> (state == ST_HOLDOVER) && $stable(cur_input);
  endproperty
  a_forced_hold: assert property (p_forced_hold)
    else $error("forced holdover changed input");

  property p_freerun;
    (mode_code == MODE_FREERUN) |=> (state == ST_FREERUN) ##1 FREERUN;
  endproperty
  a_freerun: assert property (p_freerun)
    else $error("freerun mode not reached");

  property p_revert;
    (mode_code == MODE_AUTO) && usable[best_input] && (rank[best_input] < rank[cur_input])
      |=> (cur_input == $past(best_input));
  endproperty
  a_revert: assert property (p_revert)
    else $error("did not revert to better ranked input");

  property p_no_equal_switch;
    (mode_code == MODE_AUTO) && keep_current |=> $stable(cur_input);
  endproperty
  a_no_equal_switch: assert property (p_no_equal_switch)
    else $error("switched between equal ranks");

  property p_sticky_hold;
    b_hold |=> sticky_status[B_HOLD_BIT];
  endproperty
  a_sticky_hold: assert property (p_sticky_hold)
    else $error("hold flag not set");

  property p_sticky_lock;
    b_lock && !wr_sticky ##1 !wr_sticky |-> sticky_status[B_LOCK_BIT];
  endproperty
  a_sticky_lock: assert property (p_sticky_lock)
    else $error("lock flag lost without clear");

  property p_chosen_view;
    (mode_code == MODE_AUTO) && (REG_ADDR == ADDR_OPERATING_SEL)
      |=> (REG_RDATA[CHOSEN_LSB +: 2] == $past(cur_input));
  endproperty
  a_chosen_view: assert property (p_chosen_view)
    else $error("chosen field does not show selection");

endmodule // drmc_top

/* core/drmc_pkg.sv */
package drmc_pkg;

  // Register offsets on the byte-wide register port
  localparam logic [7:0] ADDR_LOOP_CONTROL   = 8'h35;
  localparam logic [7:0] ADDR_PRIORITY_UPPER = 8'h36;
  localparam logic [7:0] ADDR_PRIORITY_LOWER = 8'h37;
  localparam logic [7:0] ADDR_OPERATING_SEL  = 8'h38;
  localparam logic [7:0] ADDR_FAILURE_MASKS  = 8'h39;
  localparam logic [7:0] ADDR_STICKY_STATUS  = 8'h44;
  localparam logic [7:0] ADDR_FEEDBACK_CTRL  = 8'h45;
  localparam logic [7:0] ADDR_LOW_POWER      = 8'h46;

  // Values after reset
  localparam logic [7:0] RST_LOOP_CONTROL    = 8'h0C;
  localparam logic [7:0] RST_PRIORITY_UPPER  = 8'h32;
  localparam logic [7:0] RST_PRIORITY_LOWER  = 8'h10;
  localparam logic [7:0] RST_OPERATING_SEL   = 8'h0F;
  localparam logic [7:0] RST_FAILURE_MASKS   = 8'h87;
  localparam logic [7:0] RST_STICKY_STATUS   = 8'h00;
  localparam logic [7:0] RST_FEEDBACK_CTRL   = 8'h00;
  localparam logic [7:0] RST_LOW_POWER       = 8'hFF;

  // Writable bits per register; the rest return their reset value
  localparam logic [7:0] WMASK_LOOP_CONTROL  = 8'hFC;
  localparam logic [7:0] WMASK_PRIORITY      = 8'h77;
  localparam logic [7:0] WMASK_OPERATING_SEL = 8'hE3;
  localparam logic [7:0] WMASK_FAILURE_MASKS = 8'hFF;
  localparam logic [7:0] WMASK_FEEDBACK_CTRL = 8'h8D;
  localparam logic [7:0] WMASK_LOW_POWER     = 8'hFF;
  localparam logic [7:0] WMASK_STICKY        = 8'h0F;

  // Field positions
  localparam int SLOPE_LSB     = 2;
  localparam int REALIGN_BIT   = 4;
  localparam int BW_LSB        = 5;
  localparam int RANK_LO_LSB   = 0;
  localparam int RANK_HI_LSB   = 4;
  localparam int MODE_LSB      = 0;
  localparam int FB_COMP_BIT   = 5;
  localparam int CHOSEN_LSB    = 6;
  localparam int HOLD_MASK_LSB = 0;
  localparam int SW_MASK_LSB   = 4;
  localparam int FB_PLL_BIT    = 0;
  localparam int FB_INPUT_LSB  = 2;
  localparam int FB_GLOBAL_BIT = 7;
  localparam int A_HOLD_BIT    = 0;
  localparam int A_LOCK_BIT    = 1;
  localparam int B_HOLD_BIT    = 2;
  localparam int B_LOCK_BIT    = 3;

  // Codes with special meaning
  localparam logic [1:0] SLOPE_UNLIMITED = 2'h3;
  localparam logic [2:0] BW_VARIABLE     = 3'h7;
  localparam logic [2:0] RANK_DISABLED   = 3'h7;

  // Operating modes
  typedef enum logic [1:0] {
    MODE_FREERUN = 2'h0,
    MODE_HOLD    = 2'h1,
    MODE_FORCED  = 2'h2,
    MODE_AUTO    = 2'h3
  } drmc_mode_t;

  // Loop condition
  typedef enum logic [1:0] {
    ST_FREERUN,
    ST_HOLDOVER,
    ST_TRACK
  } drmc_state_t;

endpackage

/* test/tb_top.sv */
`timescale 1ns/10ps

module tb_top;
  import drmc_pkg::*;

  logic       MCLK;                // 50 MHz bench clock
  logic       NRST;                // Active-low reset
  logic [7:0] REG_ADDR;            // Register offset
  logic       REG_WR;              // Write strobe
  logic [7:0] REG_WDATA;           // Write data
  logic [7:0] REG_RDATA;           // Registered read data
  logic [3:0] LOSS, SCD, CFD, GTD; // Failure detectors per input
  logic       A_HOLD, A_LOCK;      // First PLL status
  logic       B_LOCK;              // Second PLL loop lock
  logic [1:0] slope, act, fb_in;   // Observed two-bit outputs
  logic [2:0] bw;                  // Observed bandwidth code
  logic       realign, varbw, unlim, trk, hold, free, fb_comp, fb_pll, fb_glb;
  logic [7:0] low_pwr;             // Observed low-power enables
  int         fails;               // Mismatch count
  int         n_compared;          // Comparison count
  int         cycles;              // Watchdog count
  logic [7:0] rd;                  // Last read value

  drmc_top u_drmc_top (.MCLK(MCLK), .NRST(NRST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .SIGNAL_LOSS_DETECT(LOSS),
    .SINGLE_CYCLE_DETECT(SCD), .COARSE_FREQ_DETECT(CFD), .GUARD_TIMER_DETECT(GTD),
    .PLL_A_IN_HOLD(A_HOLD), .PLL_A_LOCKED(A_LOCK), .PLL_B_LOOP_LOCKED(B_LOCK),
    .SLOPE_RATE_SELECT(slope), .PHASE_REALIGN_ENABLE(realign),
    .FILTER_BANDWIDTH_SELECT(bw), .USE_VARIABLE_BANDWIDTH(varbw),
    .SLOPE_UNLIMITED_EN(unlim), .ACTIVE_INPUT(act), .TRACKING(trk), .HOLDOVER(hold),
    .FREERUN(free), .FEEDBACK_COMPENSATE_ENABLE(fb_comp), .FEEDBACK_PLL_CHOICE(fb_pll),
    .FEEDBACK_INPUT_CHOICE(fb_in), .FEEDBACK_GLOBAL_ENABLE(fb_glb),
    .OUT_LOW_POWER(low_pwr));

  // Free-running clock, 20 ns period
  initial begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end

  // Compare one value; a mismatch is reported at once
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Single-cycle write, launched on the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge MCLK);
    REG_ADDR = a; REG_WDATA = d; REG_WR = 1'b1;
    @(negedge MCLK);
    REG_WR = 1'b0;
  endtask

  // Read: address seen at one edge, data settled by the next falling edge
  task automatic rdr(input logic [7:0] a);
    @(negedge MCLK);
    REG_ADDR = a;
    @(negedge MCLK);
    rd = REG_RDATA;
  endtask

  // Detector path needs sync, state and output edges; six cycles covers it
  task automatic settle();
    repeat (6) @(negedge MCLK);
  endtask

  // Reset values of every register and the unmapped hole
  task automatic t_reset();
    logic [7:0] a[9] = '{8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h44, 8'h45, 8'h46, 8'h40};
    logic [7:0] e[9] = '{8'h0C, 8'h32, 8'h10, 8'h0F, 8'h87, 8'h00, 8'h00, 8'hFF, 8'h00};
    for (int i = 0; i < 9; i++) begin
      rdr(a[i]);
      chk(rd, e[i]);
    end
    chk(low_pwr, 8'hFF);
    chk(unlim, 1'b1);
  endtask

  // Every slope and bandwidth code, realign toggled, reserved bits held
  task automatic t_loop();
    for (int i = 0; i < 8; i++) begin
      wr(8'h35, {i[2:0], i[0], i[1:0], 2'b11});
      @(negedge MCLK);
      chk(slope, i[1:0]);
      chk(unlim, i[1:0] == 2'h3);
      chk(realign, i[0]);
      chk(bw, i[2:0]);
      chk(varbw, i[2:0] == 3'h7);
      rdr(8'h35);
      chk(rd, {i[2:0], i[0], i[1:0], 2'b00});
    end
  endtask

  // Automatic selection: revert, status readback, holdover, sticky hold
  task automatic t_auto();
    wr(8'h39, 8'hFF);
    LOSS = 4'h1; settle();
    chk(act, 2'h1);
    rdr(8'h38);
    chk(rd, 8'h4F);
    LOSS = 4'h0; settle();
    chk(act, 2'h0);
    LOSS = 4'hF; settle();
    chk(hold, 1'b1);
    wr(8'h44, 8'h04);
    rdr(8'h44);
    chk(rd, 8'h04);
    LOSS = 4'h0; settle();
    chk(trk, 1'b1);
    chk(act, 2'h0);
    wr(8'h44, 8'h04);
    rdr(8'h44);
    chk(rd, 8'h00);
  endtask

  // Equal ranks stay put; restoring distinct ranks reverts
  task automatic t_equal();
    wr(8'h37, 8'h00);
    LOSS = 4'h1; settle();
    chk(act, 2'h1);
    LOSS = 4'h0; settle();
    chk(act, 2'h1);
    wr(8'h37, 8'h10); settle();
    chk(act, 2'h0);
    wr(8'h37, 8'h17); settle();
    chk(act, 2'h1);
    wr(8'h37, 8'h10); settle();
  endtask

  // Masked detectors neither enter holdover nor trigger a switch
  task automatic t_masks();
    wr(8'h39, 8'hF0);
    LOSS = 4'hF; settle();
    chk(trk, 1'b1);
    wr(8'h39, 8'h0F);
    LOSS = 4'h1; settle();
    chk(act, 2'h0);
    chk(trk, 1'b1);
    LOSS = 4'h0;
    wr(8'h39, 8'hFF); settle();
  endtask

  // Forced input, forced holdover and freerun
  task automatic t_modes();
    wr(8'h38, 8'h82); settle();
    chk({trk, act}, 3'h6);
    rdr(8'h38);
    chk(rd, 8'h8E);
    LOSS = 4'h4; settle();
    chk({hold, act}, 3'h6);
    LOSS = 4'h0;
    wr(8'h38, 8'h21); settle();
    chk({hold, act, fb_comp}, 4'hD);
    wr(8'h38, 8'h00); settle();
    chk({free, trk, hold}, 3'h4);
    wr(8'h38, 8'h03); settle();
    chk(trk, 1'b1);
  endtask

  // Feedback control, low-power enables and sticky flags
  task automatic t_misc();
    wr(8'h45, 8'hFF);
    rdr(8'h45);
    chk(rd, 8'h8D);
    chk({fb_glb, fb_in, fb_pll}, 4'hF);
    wr(8'h45, 8'h04);
    @(negedge MCLK);
    chk({fb_glb, fb_in, fb_pll}, 4'h2);
    wr(8'h46, 8'h5A);
    @(negedge MCLK);
    chk(low_pwr, 8'h5A);
    wr(8'h44, 8'hFF);
    A_HOLD = 1'b1; A_LOCK = 1'b1; B_LOCK = 1'b1; settle();
    A_HOLD = 1'b0; A_LOCK = 1'b0; B_LOCK = 1'b0; settle();
    rdr(8'h44);
    chk(rd, 8'h0B);
    wr(8'h44, 8'h0B);
    rdr(8'h44);
    chk(rd, 8'h00);
  endtask

  // Verdict printed in one place only
  task automatic end_of_test();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Watchdog: the whole run needs well under 5000 cycles
  always @(posedge MCLK) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      end_of_test();
    end
  end

  // Main sequence
  initial begin
    fails = 0; n_compared = 0; cycles = 0;
    NRST = 1'b0; REG_ADDR = 8'h00; REG_WR = 1'b0; REG_WDATA = 8'h00;
    LOSS = 4'h0; SCD = 4'h0; CFD = 4'h0; GTD = 4'h0;
    A_HOLD = 1'b0; A_LOCK = 1'b0; B_LOCK = 1'b0;
    repeat (10) @(negedge MCLK);
    NRST = 1'b1;
    settle();
    t_reset();
    t_loop();
    t_auto();
    t_equal();
    t_masks();
    t_modes();
    t_misc();
    end_of_test();
  end
endmodule // tb_top
